// ### inc/csfp_pkg.sv
package csfp_pkg;

    // ****************************************
    // vectors and program space
    // ****************************************
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    // external interrupt n vectors at VEC_EXT0 - 2n
    localparam logic [15:0] VEC_EXT0 = 16'hFFFA;
    localparam logic [15:0] VEC_TBL15 = 16'hFFC0;
    localparam logic [3:0] TBL_TOP = 4'hF;
    // break shares the table call 0 slot
    localparam logic [3:0] BREAK_SLOT = 4'h0;
    localparam logic [7:0] PGCALL_PAGE = 8'hFF;
    localparam logic [15:0] PGCALL_LEN = 16'h0002;
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam int PROG_AW = 13;

    // ****************************************
    // registers
    // ****************************************
    localparam logic [7:0] ADDR_RPS = 8'hF3;
    localparam logic [7:0] ADDR_PSW = 8'hF4;
    localparam logic [7:0] RPS_RESET = 8'h00;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_I = 2;
    localparam int F_H = 3;
    localparam int F_B = 4;
    localparam int F_G = 5;
    localparam int F_V = 6;
    localparam int F_N = 7;
    localparam logic [2:0] PG0 = 3'h0;
    localparam logic [2:0] PG1 = 3'h1;
    localparam logic [2:0] PG4 = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_SHL = 3'h2,
        ALU_SHR = 3'h3,
        ALU_ROL = 3'h4,
        ALU_ROR = 3'h5,
        ALU_MOV = 3'h6
    } csfp_alu_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_VLO = 2'h1,
        ST_VHI = 2'h3
    } csfp_fsm_t;

    typedef struct packed {
        logic valid;
        csfp_alu_op_t op;
        logic [7:0] a;
        logic [7:0] b;
    } csfp_alu_in_t;

    typedef struct packed {
        logic c, h, v, z, n;
        logic upC, upH, upV;
    } csfp_flags_t;

    typedef struct packed {
        logic pswLoad, intOn, intOff, dpSet, dpClr, ovClr, bitTest, swBreak;
        logic tblCall;
        logic [3:0] tnum;
        logic pgCall;
        logic [7:0] poff;
        logic spLoad, push, pop, pcLoad;
        logic [1:0] pcStep;
    } csfp_cmd_t;

    typedef struct packed {
        csfp_fsm_t fsm;
        logic [15:0] vecBase;
        logic [7:0] vecLo;
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] processor_status_word;
        logic [7:0] rps;
        logic [15:0] stackAddr;
        logic [PROG_AW-1:0] progAddr;
        logic [2:0] ramPage;
        logic pageValid;
        logic [10:0] dirAddr;
        logic intGrant;
        logic vecBusy;
        logic [15:0] retAddr;
        logic [7:0] rdData;
        logic [7:0] aluRes;
    } csfp_state_t;

    localparam csfp_state_t STATE_RESET = '{
        fsm: ST_VLO, vecBase: VEC_RESET, vecLo: 8'h00, pc: 16'h0000,
        sp: SP_RESET, processor_status_word: PSW_RESET, rps: RPS_RESET,
        stackAddr: 16'h0000, progAddr: VEC_RESET[PROG_AW-1:0],
        ramPage: PG0, pageValid: 1'b1, dirAddr: 11'h000,
        intGrant: 1'b0, vecBusy: 1'b1, retAddr: 16'h0000,
        rdData: 8'h00, aluRes: 8'h00};

endpackage

// ### logic/csfp_alu_flags.sv
module csfp_alu_flags (
    input csfp_pkg::csfp_alu_op_t op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin,
    output logic [7:0] result,
    output csfp_pkg::csfp_flags_t flags
);

    logic [8:0] sum;
    logic [4:0] low;

    always_comb
    begin
        sum = 9'h000;
        low = 5'h00;
        result = 8'h00;
        flags = '0;
        unique case (op)
        csfp_pkg::ALU_ADD:
        begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            result = sum[7:0];
            flags.v = (a[7] == b[7]) && (sum[7] != a[7]);
        end
        csfp_pkg::ALU_SUB:
        begin
            // cin high means no borrow pending
            sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
            result = sum[7:0];
            flags.v = (a[7] != b[7]) && (sum[7] != a[7]);
        end
        csfp_pkg::ALU_SHL:
        begin
            result = {a[6:0], 1'b0};
            flags.c = a[7];
        end
        csfp_pkg::ALU_ROL:
        begin
            result = {a[6:0], cin};
            flags.c = a[7];
        end
        csfp_pkg::ALU_SHR:
        begin
            result = {1'b0, a[7:1]};
            flags.c = a[0];
        end
        csfp_pkg::ALU_ROR:
        begin
            result = {cin, a[7:1]};
            flags.c = a[0];
        end
        csfp_pkg::ALU_MOV:
        begin
            result = b;
        end
        default:
        begin
            result = 8'h00;
        end
        endcase
        if (op == csfp_pkg::ALU_ADD || op == csfp_pkg::ALU_SUB)
        begin
            flags.c = sum[8];
            flags.h = low[4];
            flags.upC = 1'b1;
            flags.upH = 1'b1;
            flags.upV = 1'b1;
        end
        else if (op != csfp_pkg::ALU_MOV)
        begin
            flags.upC = 1'b1;
        end
        flags.z = (result == 8'h00);
        flags.n = result[7];
    end

endmodule

// ### logic/csfp_core.sv
// Notes on behaviour
// - 16-bit pc, fetched from FFFE/FFFF after reset
// - carry takes alu carry or no-borrow, also shifts and rotates
// - zero set for a zero result or transfer, else cleared
// - interrupt enable gates interrupts; acceptance and disable clear it
// - half carry from bit 3, rewritten by every add or subtract; clear-overflow also clears it
// - software break sets the break flag
// - direct page flag 0 gives page zero, 1 uses page select
// - overflow sticky on signed overflow, cleared by clear-overflow
// - bit test copies memory bit 6 to overflow, 7 to negative
// - negative follows result bit 7
// - 8K program memory, pc wraps past FFFF to 0000
// - table call n vectors at FFC0 plus 2*(15-n)
// - page call jumps into page FF, two bytes long
// - external interrupt n vectors at FFFA minus 2n
// - page 0 while direct page flag clear, else page select
// - page codes 000, 001, 100 map pages 0, 1, 4
// - stack pointer decrements after push, increments before pop
//
// Strobed register access is this design's own decision.
module csfp_core (
    input logic clock,
    input logic rst_n,
    input logic clockEn,
    input csfp_pkg::csfp_cmd_t cmd,
    input csfp_pkg::csfp_alu_in_t aluIn,
    input logic [7:0] cmdData,
    input logic [15:0] pcTarget,
    input logic intReq,
    input logic [3:0] intNum,
    input logic [7:0] progData,
    input logic [7:0] dirOffset,
    input logic [7:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWr,
    input logic regRd,
    output logic [7:0] regRdData,
    output logic [15:0] pcOut,
    output logic [7:0] pswOut,
    output logic [7:0] spOut,
    output logic [15:0] stackAddr,
    output logic [12:0] progAddr,
    output logic vecBusy,
    output logic intGrant,
    output logic [15:0] retAddr,
    output logic [7:0] aluResult,
    output logic [2:0] ramPage,
    output logic pageValid,
    output logic [10:0] dirAddr
);

    // ****************************************
    // state and alu
    // ****************************************
    csfp_pkg::csfp_state_t st_reg;
    csfp_pkg::csfp_state_t st_next;
    csfp_pkg::csfp_flags_t af;
    logic [7:0] aluRes;
    logic run;
    logic idle;

    csfp_alu_flags csfp_alu_flags_inst (
        .op(aluIn.op),
        .a(aluIn.a),
        .b(aluIn.b),
        .cin(st_reg.processor_status_word[csfp_pkg::F_C]),
        .result(aluRes),
        .flags(af)
    );

    assign run = (st_reg.fsm == csfp_pkg::ST_RUN);
    // interrupts only between commands, so taking one drops no command
    assign idle = (cmd == '0) && !aluIn.valid;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.intGrant = 1'b0;
        st_next.rdData = 8'h00;
        unique case (st_reg.fsm)
        csfp_pkg::ST_VLO:
        begin
            st_next.vecLo = progData;
            st_next.fsm = csfp_pkg::ST_VHI;
        end
        csfp_pkg::ST_VHI:
        begin
            st_next.pc = {progData, st_reg.vecLo};
            st_next.fsm = csfp_pkg::ST_RUN;
        end
        csfp_pkg::ST_RUN:
        begin
            if (intReq && st_reg.processor_status_word[csfp_pkg::F_I] && idle)
            begin
                st_next.processor_status_word[csfp_pkg::F_I] = 1'b0;
                st_next.intGrant = 1'b1;
                st_next.vecBase = csfp_pkg::VEC_EXT0
                    - {11'h000, intNum, 1'b0};
                st_next.fsm = csfp_pkg::ST_VLO;
            end
            else
            begin
                if (cmd.pswLoad)
                begin
                    st_next.processor_status_word = cmdData;
                end
                if (cmd.intOn)
                begin
                    st_next.processor_status_word[csfp_pkg::F_I] = 1'b1;
                end
                if (cmd.intOff)
                begin
                    st_next.processor_status_word[csfp_pkg::F_I] = 1'b0;
                end
                if (cmd.dpSet)
                begin
                    st_next.processor_status_word[csfp_pkg::F_G] = 1'b1;
                end
                if (cmd.dpClr)
                begin
                    st_next.processor_status_word[csfp_pkg::F_G] = 1'b0;
                end
                // clear before alu so a new set wins
                if (cmd.ovClr)
                begin
                    st_next.processor_status_word[csfp_pkg::F_H] = 1'b0;
                    st_next.processor_status_word[csfp_pkg::F_V] = 1'b0;
                end
                if (aluIn.valid)
                begin
                    st_next.aluRes = aluRes;
                    if (af.upC)
                    begin
                        st_next.processor_status_word[csfp_pkg::F_C] = af.c;
                    end
                    if (af.upH)
                    begin
                        st_next.processor_status_word[csfp_pkg::F_H] = af.h;
                    end
                    if (af.upV)
                    begin
                        st_next.processor_status_word[csfp_pkg::F_V] =
                            st_next.processor_status_word[csfp_pkg::F_V] | af.v;
                    end
                    st_next.processor_status_word[csfp_pkg::F_Z] = af.z;
                    st_next.processor_status_word[csfp_pkg::F_N] = af.n;
                end
                if (cmd.bitTest)
                begin
                    st_next.processor_status_word[csfp_pkg::F_V] = cmdData[6];
                    st_next.processor_status_word[csfp_pkg::F_N] = cmdData[7];
                end
                if (cmd.spLoad)
                begin
                    st_next.sp = cmdData;
                end
                else if (cmd.push)
                begin
                    st_next.stackAddr = {csfp_pkg::STACK_PAGE, st_reg.sp};
                    st_next.sp = st_reg.sp - 8'h01;
                end
                else if (cmd.pop)
                begin
                    st_next.sp = st_reg.sp + 8'h01;
                    st_next.stackAddr = {csfp_pkg::STACK_PAGE,
                        st_next.sp};
                end
                if (cmd.swBreak)
                begin
                    st_next.processor_status_word[csfp_pkg::F_B] = 1'b1;
                    st_next.vecBase = csfp_pkg::VEC_TBL15 + {11'h000,
                        csfp_pkg::TBL_TOP - csfp_pkg::BREAK_SLOT, 1'b0};
                    st_next.fsm = csfp_pkg::ST_VLO;
                end
                else if (cmd.tblCall)
                begin
                    st_next.vecBase = csfp_pkg::VEC_TBL15 + {11'h000,
                        csfp_pkg::TBL_TOP - cmd.tnum, 1'b0};
                    st_next.fsm = csfp_pkg::ST_VLO;
                end
                else if (cmd.pgCall)
                begin
                    st_next.retAddr = st_reg.pc + csfp_pkg::PGCALL_LEN;
                    st_next.pc = {csfp_pkg::PGCALL_PAGE, cmd.poff};
                end
                else if (cmd.pcLoad)
                begin
                    st_next.pc = pcTarget;
                end
                else
                begin
                    st_next.pc = st_reg.pc + {14'h0000, cmd.pcStep};
                end
            end
        end
        default:
        begin
            st_next.fsm = csfp_pkg::ST_VLO;
            st_next.vecBase = csfp_pkg::VEC_RESET;
        end
        endcase

        // ****************************************
        // register port
        // ****************************************
        if (regWr && regAddr == csfp_pkg::ADDR_RPS)
        begin
            st_next.rps = regWrData;
        end
        if (regRd)
        begin
            if (regAddr == csfp_pkg::ADDR_RPS)
            begin
                st_next.rdData = st_reg.rps;
            end
            else if (regAddr == csfp_pkg::ADDR_PSW)
            begin
                st_next.rdData = st_reg.processor_status_word;
            end
        end

        if (st_next.fsm == csfp_pkg::ST_RUN)
        begin
            st_next.progAddr = st_next.pc[12:0];
        end
        else if (st_next.fsm == csfp_pkg::ST_VLO)
        begin
            st_next.progAddr = st_next.vecBase[12:0];
        end
        else
        begin
            st_next.progAddr = st_reg.vecBase[12:0] + 13'h0001;
        end
        st_next.vecBusy = (st_next.fsm != csfp_pkg::ST_RUN);

        st_next.pageValid = 1'b1;
        st_next.ramPage = csfp_pkg::PG0;
        if (st_next.processor_status_word[csfp_pkg::F_G])
        begin
            unique case (st_next.rps[2:0])
            csfp_pkg::PG0, csfp_pkg::PG1, csfp_pkg::PG4:
            begin
                st_next.ramPage = st_next.rps[2:0];
            end
            default:
            begin
                st_next.pageValid = 1'b0;
            end
            endcase
        end
        st_next.dirAddr = {st_reg.ramPage, dirOffset};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= csfp_pkg::STATE_RESET;
        end
        else if (clockEn)
        begin
            st_reg <= st_next;
        end
    end

    assign regRdData = st_reg.rdData;
    assign pcOut = st_reg.pc;
    assign pswOut = st_reg.processor_status_word;
    assign spOut = st_reg.sp;
    assign stackAddr = st_reg.stackAddr;
    assign progAddr = st_reg.progAddr;
    assign vecBusy = st_reg.vecBusy;
    assign intGrant = st_reg.intGrant;
    assign retAddr = st_reg.retAddr;
    assign aluResult = st_reg.aluRes;
    assign ramPage = st_reg.ramPage;
    assign pageValid = st_reg.pageValid;
    assign dirAddr = st_reg.dirAddr;

    // ****************************************
    // checks
    // ****************************************
    logic act;
    logic ovClrFire;
    logic loadFire;
    assign act = clockEn && run;
    assign ovClrFire = act && !(intReq && st_reg.processor_status_word[csfp_pkg::F_I] && idle)
        && cmd.ovClr;
    assign loadFire = act && cmd.pswLoad;

    vec_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.fsm == csfp_pkg::ST_VHI && clockEn |=>
        st_reg.pc == {$past(progData), $past(st_reg.vecLo)} && run)
        else $error("pc not loaded from vector");
    carry_cap_a: assert property (@(posedge clock) disable iff (!rst_n)
        act && !cmd.pswLoad && aluIn.valid && af.upC |=>
        st_reg.processor_status_word[csfp_pkg::F_C] == $past(af.c))
        else $error("carry not captured");
    zero_neg_a: assert property (@(posedge clock) disable iff (!rst_n)
        act && aluIn.valid && !cmd.bitTest |=>
        st_reg.processor_status_word[csfp_pkg::F_Z] == (st_reg.aluRes == 8'h00)
        && st_reg.processor_status_word[csfp_pkg::F_N] == st_reg.aluRes[7])
        else $error("zero or negative wrong");
    int_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.intGrant |-> !st_reg.processor_status_word[csfp_pkg::F_I]
        && st_reg.fsm == csfp_pkg::ST_VLO && $past(st_reg.processor_status_word[csfp_pkg::F_I]))
        else $error("interrupt taken while disabled");
    ovf_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(st_reg.processor_status_word[csfp_pkg::F_V]) |->
        $past(ovClrFire) || $past(loadFire) || $past(cmd.bitTest))
        else $error("overflow cleared without cause");
    break_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
        act && cmd.swBreak && !idle |=> st_reg.processor_status_word[csfp_pkg::F_B]
        ##1 st_reg.progAddr == 13'h1FDF)
        else $error("break not flagged or vectored");
    page_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        !st_reg.processor_status_word[csfp_pkg::F_G] |->
        st_reg.ramPage == csfp_pkg::PG0 && st_reg.pageValid)
        else $error("page not zero with flag clear");
    page_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.processor_status_word[csfp_pkg::F_G] |->
        st_reg.pageValid == (st_reg.rps[2:0] inside {3'h0, 3'h1, 3'h4}))
        else $error("page decode wrong");
    int_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.intGrant |->
        st_reg.vecBase == 16'hFFFA - {11'h000, $past(intNum), 1'b0})
        else $error("interrupt vector wrong");
    push_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
        act && idle == 1'b0 && cmd.push && !cmd.spLoad |=>
        st_reg.sp == $past(st_reg.sp) - 8'h01
        && st_reg.stackAddr[7:0] == $past(st_reg.sp))
        else $error("push order wrong");

endmodule

// ### testbench/csfp_prog_rom.sv
// ****************************************
// program memory model
// ****************************************
module csfp_prog_rom (
    input logic [12:0] progAddr,
    output logic [7:0] progData
);
    timeunit 1ns;
    timeprecision 1ns;

    // 8K program space
    // byte pattern lets every vector word be predicted
    assign progData = progAddr[7:0] + 8'h11;
endmodule

// ### testbench/csfp_core_tb.sv
module csfp_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] pre;
        csfp_pkg::csfp_alu_op_t op;
        logic [7:0] a, b, res, processor_status_word;
    } csfp_row_t;

    localparam csfp_row_t ROWS [8] = '{
        '{8'h00, csfp_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'hC8},
        '{8'h00, csfp_pkg::ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'h0B},
        '{8'h01, csfp_pkg::ALU_SUB, 8'h80, 8'h01, 8'h7F, 8'h41},
        '{8'h01, csfp_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h0B},
        '{8'h00, csfp_pkg::ALU_SHL, 8'h81, 8'h81, 8'h02, 8'h01},
        '{8'h00, csfp_pkg::ALU_SHR, 8'h01, 8'h01, 8'h00, 8'h03},
        '{8'h00, csfp_pkg::ALU_ROL, 8'h40, 8'h40, 8'h80, 8'h80},
        '{8'h80, csfp_pkg::ALU_MOV, 8'h00, 8'h00, 8'h00, 8'h02}};

    logic clock, rst_n, clockEn, intReq, regWr, regRd;
    csfp_pkg::csfp_cmd_t cmd;
    csfp_pkg::csfp_alu_in_t aluIn;
    logic [7:0] cmdData, progData, dirOffset, regAddr, regWrData;
    logic [15:0] pcTarget, pcOut, stackAddr, retAddr;
    logic [3:0] intNum;
    logic [7:0] regRdData, pswOut, spOut, aluResult;
    logic [12:0] progAddr;
    logic vecBusy, intGrant, pageValid;
    logic [2:0] ramPage;
    logic [10:0] dirAddr;
    int num_errors = 0;
    int checks_done = 0;

    csfp_core csfp_core_inst (.clock(clock), .rst_n(rst_n),
        .clockEn(clockEn), .cmd(cmd), .aluIn(aluIn), .cmdData(cmdData),
        .pcTarget(pcTarget), .intReq(intReq), .intNum(intNum),
        .progData(progData), .dirOffset(dirOffset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .pcOut(pcOut), .pswOut(pswOut),
        .spOut(spOut), .stackAddr(stackAddr), .progAddr(progAddr),
        .vecBusy(vecBusy), .intGrant(intGrant), .retAddr(retAddr),
        .aluResult(aluResult), .ramPage(ramPage), .pageValid(pageValid),
        .dirAddr(dirAddr));

    csfp_prog_rom csfp_prog_rom_inst (.progAddr(progAddr),
        .progData(progData));

    initial clock = 1'b0;
    always #50 clock = ~clock;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] vecOf(input logic [15:0] base);
        return {base[7:0] + 8'h12, base[7:0] + 8'h11};
    endfunction

    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    // strobes drop at the edge that takes them
    task automatic go;
        @(posedge clock);
        cmd <= '0;
        aluIn.valid <= 1'b0;
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1;
    endtask

    task automatic waitVec;
        int n;
        n = 0;
        while (vecBusy !== 1'b0 && n < 10)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("vecBusy", 16'h0, 16'(vecBusy));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        go();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        go();
        chk("regRdData", 16'(e), 16'(regRdData));
    endtask

    task automatic alu(input csfp_row_t r);
        @(posedge clock) cmd.pswLoad <= 1'b1;
        cmdData <= r.pre;
        go();
        @(posedge clock) aluIn <= '{1'b1, r.op, r.a, r.b};
        go();
        chk("aluResult", 16'(r.res), 16'(aluResult));
    endtask

    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        clockEn = 1'b1;
        cmd = '0;
        aluIn = '0;
        cmdData = 8'h00;
        pcTarget = 16'h0000;
        intReq = 1'b0;
        intNum = 4'h1;
        dirOffset = 8'hAB;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        chk("progAddr", 16'h1FFE, 16'(progAddr));
        chk("psw", 16'(csfp_pkg::PSW_RESET), 16'(pswOut));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        waitVec();
        chk("pc", vecOf(16'hFFFE), pcOut);
        rd(csfp_pkg::ADDR_RPS, csfp_pkg::RPS_RESET);
        $display("test reset done");

        for (int i = 0; i < 8; i++)
        begin
            alu(ROWS[i]);
            chk("psw", 16'(ROWS[i].processor_status_word), 16'(pswOut));
        end
        $display("test alu table done");

        alu('{8'h00, csfp_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'hC8});
        alu('{8'hC8, csfp_pkg::ALU_ADD, 8'h0F, 8'h01, 8'h10, 8'h00});
        chk("psw", 16'h0048, 16'(pswOut));
        @(posedge clock) cmd.ovClr <= 1'b1;
        go();
        chk("psw", 16'h0000, 16'(pswOut));
        @(posedge clock) cmd.bitTest <= 1'b1;
        cmdData <= 8'hC0;
        go();
        chk("psw", 16'h00C0, 16'(pswOut));
        @(posedge clock) cmd.intOn <= 1'b1;
        go();
        chk("psw", 16'h00C4, 16'(pswOut));
        @(posedge clock) cmd.intOff <= 1'b1;
        go();
        @(posedge clock) intReq <= 1'b1;
        repeat (3)
        begin
            @(posedge clock);
            #1;
            chk("intGrant", 16'h0, 16'(intGrant));
        end
        @(posedge clock) intReq <= 1'b0;
        cmd.intOn <= 1'b1;
        go();
        @(posedge clock) intReq <= 1'b1;
        @(posedge clock) intReq <= 1'b0;
        #1;
        chk("intGrant", 16'h1, 16'(intGrant));
        chk("progAddr", 16'h1FF8, 16'(progAddr));
        chk("psw", 16'h00C0, 16'(pswOut));
        waitVec();
        chk("pc", vecOf(16'hFFF8), pcOut);
        $display("test flags and interrupt done");

        @(posedge clock) cmd.tblCall <= 1'b1;
        cmd.tnum <= 4'hF;
        go();
        chk("progAddr", 16'h1FC0, 16'(progAddr));
        waitVec();
        chk("pc", vecOf(16'hFFC0), pcOut);
        chk("psw", 16'h00C0, 16'(pswOut));
        @(posedge clock) cmd.tblCall <= 1'b1;
        cmd.tnum <= 4'hE;
        go();
        waitVec();
        chk("pc", vecOf(16'hFFC2), pcOut);
        @(posedge clock) cmd.swBreak <= 1'b1;
        go();
        chk("progAddr", 16'h1FDE, 16'(progAddr));
        waitVec();
        chk("psw", 16'h00D0, 16'(pswOut));
        @(posedge clock) cmd.pgCall <= 1'b1;
        cmd.poff <= 8'h35;
        go();
        chk("pc", 16'hFF35, pcOut);
        chk("retAddr", vecOf(16'hFFDE) + 16'h0002, retAddr);
        @(posedge clock) cmd.pcLoad <= 1'b1;
        pcTarget <= 16'hFFFF;
        go();
        @(posedge clock) cmd.pcStep <= 2'h1;
        go();
        chk("pc", 16'h0000, pcOut);
        settle();
        chk("progAddr", 16'h0000, 16'(progAddr));
        // clock enable low must hold the pc
        @(posedge clock) clockEn <= 1'b0;
        cmd.pcStep <= 2'h2;
        go();
        chk("pcFrozen", 16'h0000, pcOut);
        @(posedge clock) clockEn <= 1'b1;
        $display("test vectors done");

        @(posedge clock) cmd.spLoad <= 1'b1;
        cmdData <= 8'h5F;
        go();
        @(posedge clock) cmd.push <= 1'b1;
        go();
        chk("stackAddr", 16'h015F, stackAddr);
        chk("sp", 16'h005E, 16'(spOut));
        @(posedge clock) cmd.pop <= 1'b1;
        go();
        chk("stackAddr", 16'h015F, stackAddr);
        $display("test stack done");

        wr(csfp_pkg::ADDR_RPS, 8'h04);
        rd(csfp_pkg::ADDR_RPS, 8'h04);
        @(posedge clock);
        #1;
        chk("regRdData", 16'h0, 16'(regRdData));
        chk("ramPage", 16'h0, 16'(ramPage));
        wr(csfp_pkg::ADDR_PSW, 8'hFF);
        rd(csfp_pkg::ADDR_PSW, 8'hD0);
        rd(8'h10, 8'h00);
        // direct page set after page select
        @(posedge clock) cmd.dpSet <= 1'b1;
        go();
        settle();
        chk("ramPage", 16'h4, 16'(ramPage));
        chk("dirAddr", 16'h04AB, 16'(dirAddr));
        wr(csfp_pkg::ADDR_RPS, 8'h02);
        settle();
        chk("pageValid", 16'h0, 16'(pageValid));
        wr(csfp_pkg::ADDR_RPS, 8'h01);
        settle();
        chk("ramPage", 16'h1, 16'(ramPage));
        @(posedge clock) cmd.dpClr <= 1'b1;
        go();
        settle();
        chk("ramPage", 16'h0, 16'(ramPage));
        chk("dirAddr", 16'h00AB, 16'(dirAddr));
        $display("test paging done");

        @(posedge clock) rst_n <= 1'b0;
        #1;
        chk("psw", 16'(csfp_pkg::PSW_RESET), 16'(pswOut));
        chk("vecBusy", 16'h1, 16'(vecBusy));
        $display("test second reset done");
        results();
    end

    // hang guard at 2000 cycles, far beyond the fewer than 200 cycles of the run
    initial
    begin
        #200000;
        num_errors++;
        results();
    end
endmodule
